// *** hdl/pwmcg_pkg.sv ***
// pwmcg_pkg: register map, field positions, reset values and timing counts for the pwm channel generator
`default_nettype none
package pwmcg_pkg;
  // ------------------------------------------------------------
  // clock and time bases
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 20_000_000;  // core clock rate
  localparam int unsigned TB_1MS_US        = 1000;        // 1 ms tick in us
  localparam int unsigned TB_100US_US      = 100;         // 0.1 ms tick in us
  localparam int unsigned TB_1US_US        = 1;           // 1 us tick in us
  localparam int unsigned CYC_PER_US       = CLK_HZ / 1_000_000;
  localparam logic [15:0] TB_1MS_CYC       = 16'(TB_1MS_US * CYC_PER_US);
  localparam logic [15:0] TB_100US_CYC     = 16'(TB_100US_US * CYC_PER_US);
  localparam logic [15:0] TB_1US_CYC       = 16'(TB_1US_US * CYC_PER_US);
  // ------------------------------------------------------------
  // output formats and limits
  // ------------------------------------------------------------
  localparam logic [15:0] PERMIL_FULL      = 16'h03e8;    // 1000
  localparam logic [15:0] ANALOG_FULL      = 16'h6c00;    // 27648
  localparam logic [15:0] ONDLY_MAX        = 16'hffff;    // 65535 ticks
  localparam logic [15:0] PERIOD_MAX       = 16'h0057;    // 87 ticks
  // ------------------------------------------------------------
  // register offsets (word addresses, register index = avs_address[2:0])
  // ------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL         = 4'h0;        // enable, mode, format, time base
  localparam logic [3:0]  REG_VALUE        = 4'h1;        // commanded output value
  localparam logic [3:0]  REG_ONDLY        = 4'h2;        // on-delay in ticks
  localparam logic [3:0]  REG_PERIOD       = 4'h3;        // period in ticks
  localparam logic [3:0]  REG_MINPW        = 4'h4;        // minimum pulse duration in ticks
  localparam logic [3:0]  REG_STATUS       = 4'h5;        // running state, output level, high time
  localparam int unsigned CH_STRIDE        = 8;           // word index stride per channel
  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  localparam int unsigned CTRL_EN_BIT      = 0;
  localparam int unsigned CTRL_MODE_BIT    = 1;           // 0 pwm, 1 pulse train
  localparam int unsigned CTRL_FMT_BIT     = 2;           // 0 per mil, 1 analog scale
  localparam int unsigned CTRL_TB_LSB      = 4;           // two-bit time base
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [1:0]  TB_RESET         = 2'h1;        // 0.1 ms
  localparam logic [15:0] ONDLY_RESET      = 16'h0000;
  localparam logic [15:0] PERIOD_RESET     = 16'h0032;    // 50 ticks
  localparam logic [15:0] MINPW_RESET      = 16'h0002;
  localparam logic [31:0] UNMAPPED_READ    = 32'h00000000;

  // time base selection
  typedef enum logic [1:0] {PWMCG_TB_1MS, PWMCG_TB_100US, PWMCG_TB_1US, PWMCG_TB_RSV} pwmcg_tb_t;
endpackage
`default_nettype wire

// *** hdl/pwmcg_tick.sv ***
// pwmcg_tick: divider that emits a one-cycle tick at the selected time base
`default_nettype none
module pwmcg_tick
  import pwmcg_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_sync_n,
  // control
  input  wire logic       run,
  input  wire logic [1:0] tb_sel,
  // tick
  output logic            tick
);
  logic [15:0] cnt_reg;   // cycle counter
  logic [15:0] cnt_next;
  logic [15:0] div;       // cycles per tick

  // ------------------------------------------------------------
  // divider
  // ------------------------------------------------------------
  // pick divider; reserved code falls back to 0.1 ms
  always_comb begin
    unique case (tb_sel)
      2'h0:    div = TB_1MS_CYC;
      2'h2:    div = TB_1US_CYC;
      default: div = TB_100US_CYC;
    endcase
    tick     = run && (cnt_reg == div - 16'h0001);
    cnt_next = (!run || tick) ? 16'h0000 : cnt_reg + 16'h0001;
  end

  // register the counter
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

// *** hdl/pwmcg_chan.sv ***
// pwmcg_chan: one output channel with on-delay, period, scaled high time and spike suppression
`default_nettype none
module pwmcg_chan
  import pwmcg_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_sync_n,
  // configuration
  input  wire logic        enable,
  input  wire logic        mode_train,
  input  wire logic        fmt_analog,
  input  wire logic [1:0]  tb_sel,
  input  wire logic [15:0] value,
  input  wire logic [15:0] on_delay,
  input  wire logic [15:0] period,
  input  wire logic [15:0] min_pulse,
  // state
  output logic             running,
  output logic [15:0]      high_ticks,
  // pin
  output logic             pwm_out
);
  typedef enum logic [1:0] {PWMCG_IDLE, PWMCG_DELAY, PWMCG_CYCLE} pwmcg_state_t;

  pwmcg_state_t state_reg, state_next;  // sequence state
  logic [15:0]  cnt_reg, cnt_next;      // tick count within phase
  logic [15:0]  hi_reg, hi_next;        // high time latched per period
  logic         out_reg, out_next;      // registered pin level
  logic         tick;                   // time base tick
  logic         pwm_act;                // pwm selected and enabled
  logic [15:0]  hi_calc;                // scaled high time

  // scale value * period / full, clamping over-range values
  function automatic logic [15:0] scale(input logic [15:0] v, input logic [15:0] p,
                                        input logic [15:0] mp, input logic an);
    logic [15:0] full;
    logic [15:0] vc;
    logic [31:0] prod;
    logic [15:0] h;
    full = an ? ANALOG_FULL : PERMIL_FULL;
    vc   = (v > full) ? full : v;
    prod = vc * p;
    h    = 16'(prod / {16'h0000, full});
    if (h < mp) begin
      h = 16'h0000;                          // short pulse dropped
    end else if ((p - h) < mp) begin
      h = p;                                 // short pause dropped
    end
    return h;
  endfunction

  // shared channel: pulse train mode leaves pwm path idle
  assign pwm_act = enable && !mode_train;
  assign hi_calc = scale(value, period, min_pulse, fmt_analog);

  pwmcg_tick u_tick (
    .core_clk   (core_clk),
    .rst_sync_n (rst_sync_n),
    .run        (pwm_act),
    .tb_sel     (tb_sel),
    .tick       (tick)
  );

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // next-state for delay and cycle phases
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    hi_next    = hi_reg;
    out_next   = 1'b0;
    unique case (state_reg)
      PWMCG_IDLE: begin
        if (pwm_act) begin
          state_next = (on_delay == 16'h0000) ? PWMCG_CYCLE : PWMCG_DELAY;
          cnt_next   = 16'h0000;
          hi_next    = hi_calc;
        end
      end
      PWMCG_DELAY: begin
        if (tick) begin
          if (cnt_reg + 16'h0001 >= on_delay) begin
            state_next = PWMCG_CYCLE;
            cnt_next   = 16'h0000;
            hi_next    = hi_calc;
          end else begin
            cnt_next = cnt_reg + 16'h0001;
          end
        end
      end
      PWMCG_CYCLE: begin
        if (tick) begin
          if (cnt_reg + 16'h0001 >= period) begin    // period wraps
            cnt_next = 16'h0000;
            hi_next  = hi_calc;
          end else begin
            cnt_next = cnt_reg + 16'h0001;
          end
        end
      end
      default: begin
        state_next = PWMCG_IDLE;
      end
    endcase
    // high only in cycle phase below the high time
    if (state_next == PWMCG_CYCLE) begin
      out_next = (cnt_next < hi_next);
    end
    if (!pwm_act) begin
      state_next = PWMCG_IDLE;
      out_next   = 1'b0;
    end
  end

  // register sequencer state
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= PWMCG_IDLE;
      cnt_reg   <= 16'h0000;
      hi_reg    <= 16'h0000;
      out_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      hi_reg    <= hi_next;
      out_reg   <= out_next;
    end
  end

  assign running    = (state_reg != PWMCG_IDLE);
  assign high_ticks = hi_reg;
  assign pwm_out    = out_reg;
endmodule
`default_nettype wire

// *** hdl/pwmcg_top.sv ***
// pwmcg_top: two pwm channels behind an avalon-mm register slave
`default_nettype none
module pwmcg_top
  import pwmcg_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // pwm outputs
  output logic [1:0]       pwm_out
);
  localparam int unsigned NCH = 2;           // pwm-capable channels only

  logic        rst_s1_reg, rst_sync_n;       // reset release synchroniser
  logic        ack_reg, ack_next;            // one wait cycle then answer
  logic [31:0] rd_reg, rd_next;              // registered read data
  logic [5:0]  ctrl_reg   [NCH];             // control fields per channel
  logic [15:0] value_reg  [NCH];
  logic [15:0] ondly_reg  [NCH];
  logic [15:0] period_reg [NCH];
  logic [15:0] minpw_reg  [NCH];
  logic [5:0]  ctrl_next  [NCH];
  logic [15:0] value_next [NCH];
  logic [15:0] ondly_next [NCH];
  logic [15:0] period_next[NCH];
  logic [15:0] minpw_next [NCH];
  logic [NCH-1:0] running;                   // channel sequence active
  logic [15:0] high_ticks [NCH];
  logic        ch_sel;                       // addressed channel
  logic        ch_ok;                        // address inside a channel
  logic [3:0]  reg_idx;                      // word within channel block

  // byte-lane merge for 16-bit fields
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) r[7:0]  = wd[7:0];
    if (be[1]) r[15:8] = wd[15:8];
    return r;
  endfunction

  // clamp to upper limit
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lim);
    return (v > lim) ? lim : v;
  endfunction

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  // two-stage release of the asynchronous reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_sync_n <= rst_s1_reg;
    end
  end

  // ------------------------------------------------------------
  // bus decode and register file
  // ------------------------------------------------------------
  assign ch_sel  = avs_address[3];
  assign reg_idx = {1'b0, avs_address[2:0]};
  assign ch_ok   = !avs_address[5] && !avs_address[4];

  // next values of registers and bus answer
  always_comb begin
    ack_next = (avs_read || avs_write) && !ack_reg;
    rd_next  = rd_reg;
    for (int i = 0; i < NCH; i++) begin
      ctrl_next[i]   = ctrl_reg[i];
      value_next[i]  = value_reg[i];
      ondly_next[i]  = ondly_reg[i];
      period_next[i] = period_reg[i];
      minpw_next[i]  = minpw_reg[i];
    end
    // write takes effect on the answering cycle
    if (avs_write && ack_reg && ch_ok) begin
      for (int i = 0; i < NCH; i++) begin
        if (ch_sel == 1'(i)) begin
          unique case (reg_idx)
            REG_CTRL:   if (avs_byteenable[0]) ctrl_next[i] = avs_writedata[5:0];
            REG_VALUE:  value_next[i]  = merge16(value_reg[i], avs_writedata, avs_byteenable);
            REG_ONDLY:  ondly_next[i]  = clamp16(merge16(ondly_reg[i], avs_writedata, avs_byteenable),
                                                 ONDLY_MAX);
            REG_PERIOD: period_next[i] = clamp16(merge16(period_reg[i], avs_writedata, avs_byteenable),
                                                 PERIOD_MAX);
            REG_MINPW:  minpw_next[i]  = clamp16(merge16(minpw_reg[i], avs_writedata, avs_byteenable),
                                                 {1'b0, period_next[i][15:1]});  // half period
            default:    ;
          endcase
        end
      end
    end
    // read data prepared in the wait cycle
    if (avs_read && !ack_reg) begin
      rd_next = UNMAPPED_READ;
      if (ch_ok) begin
        unique case (reg_idx)
          REG_CTRL:   rd_next = {26'h0, ctrl_reg[ch_sel]};
          REG_VALUE:  rd_next = {16'h0, value_reg[ch_sel]};
          REG_ONDLY:  rd_next = {16'h0, ondly_reg[ch_sel]};
          REG_PERIOD: rd_next = {16'h0, period_reg[ch_sel]};
          REG_MINPW:  rd_next = {16'h0, minpw_reg[ch_sel]};
          REG_STATUS: rd_next = {high_ticks[ch_sel], 14'h0, pwm_out[ch_sel], running[ch_sel]};
          default:    rd_next = UNMAPPED_READ;
        endcase
      end
    end
  end

  // register the file
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ack_reg <= 1'b0;
      rd_reg  <= 32'h00000000;
      for (int i = 0; i < NCH; i++) begin
        ctrl_reg[i]   <= {TB_RESET, 4'h0};   // 0.1 ms, pwm, per mil, off
        value_reg[i]  <= 16'h0000;
        ondly_reg[i]  <= ONDLY_RESET;
        period_reg[i] <= PERIOD_RESET;
        minpw_reg[i]  <= MINPW_RESET;
      end
    end else begin
      ack_reg <= ack_next;
      rd_reg  <= rd_next;
      for (int i = 0; i < NCH; i++) begin
        ctrl_reg[i]   <= ctrl_next[i];
        value_reg[i]  <= value_next[i];
        ondly_reg[i]  <= ondly_next[i];
        period_reg[i] <= period_next[i];
        minpw_reg[i]  <= minpw_next[i];
      end
    end
  end

  // waitrequest high until the answering cycle
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign avs_readdata    = rd_reg;

  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    pwmcg_chan u_chan (
      .core_clk   (core_clk),
      .rst_sync_n (rst_sync_n),
      .enable     (ctrl_reg[g][CTRL_EN_BIT]),
      .mode_train (ctrl_reg[g][CTRL_MODE_BIT]),
      .fmt_analog (ctrl_reg[g][CTRL_FMT_BIT]),
      .tb_sel     (ctrl_reg[g][CTRL_TB_LSB +: 2]),
      .value      (value_reg[g]),
      .on_delay   (ondly_reg[g]),
      .period     (period_reg[g]),
      .min_pulse  (minpw_reg[g]),
      .running    (running[g]),
      .high_ticks (high_ticks[g]),
      .pwm_out    (pwm_out[g])
    );
  end
endmodule
`default_nettype wire

// *** sim/pwmcg_sva.sv ***
// pwmcg_sva: handshake and output timing checks on the pwmcg_top ports
`default_nettype none
module pwmcg_sva (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // register bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // output lines
  input wire logic [1:0]  pwm_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // bus handshake: one wait cycle, data held
  // ----------------------------------------
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("request stalled past one cycle");
  property p_idle;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("wait raised without request");
  property p_rd_hold;
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  // ----------------------------------------
  // output lines: low after reset, no spikes
  // ----------------------------------------
  property p_rst_low;
    $rose(rst_n) |-> (pwm_out == 2'h0) [*4];
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("output high after reset");
  // a write may cut a pulse short, so checks pause while one is on the bus
  property p_hi0;
    disable iff (!rst_n || avs_write) $rose(pwm_out[0]) |=> pwm_out[0] [*8];
  endproperty
  a_hi0: assert property (p_hi0) else $error("short pulse on line 0");
  property p_lo0;
    disable iff (!rst_n || avs_write) $fell(pwm_out[0]) |=> !pwm_out[0] [*8];
  endproperty
  a_lo0: assert property (p_lo0) else $error("short pause on line 0");
  property p_hi1;
    disable iff (!rst_n || avs_write) $rose(pwm_out[1]) |=> pwm_out[1] [*8];
  endproperty
  a_hi1: assert property (p_hi1) else $error("short pulse on line 1");
  property p_lo1;
    disable iff (!rst_n || avs_write) $fell(pwm_out[1]) |=> !pwm_out[1] [*8];
  endproperty
  a_lo1: assert property (p_lo1) else $error("short pause on line 1");
  // main scenarios reached
  c_read: cover property (avs_read && !avs_waitrequest);
  c_rise0: cover property ($rose(pwm_out[0]));
  c_rise1: cover property ($rose(pwm_out[1]));
endmodule
bind pwmcg_top pwmcg_sva pwmcg_sva_inst (
  .core_clk(core_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pwm_out(pwm_out));
`default_nettype wire

// *** sim/pwmcg_actuator.sv ***
// pwmcg_actuator: actuator model that times the pulses on one output line
`default_nettype none
module pwmcg_actuator (
  // clock and line
  input  wire logic core_clk,
  input  wire logic line_in,
  // last high length and rise-to-rise distance, in clock cycles
  output var int    hi_cyc,
  output var int    per_cyc
);
  timeunit 1ns;
  timeprecision 1ns;
  int   run_cyc  = 0;    // cycles since the last rise
  logic last_lvl = 1'b0; // line level at the previous edge
  initial begin
    hi_cyc = 0;
    per_cyc = 0;
  end
  // time each high pulse and each full cycle
  always @(posedge core_clk) begin
    last_lvl <= line_in;
    run_cyc <= run_cyc + 1;
    if (line_in === 1'b1 && last_lvl === 1'b0) begin
      per_cyc <= run_cyc;
      run_cyc <= 1;
    end
    if (line_in === 1'b0 && last_lvl === 1'b1) begin
      hi_cyc <= run_cyc;
    end
  end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// testbench: register, pwm timing and reset tests for pwmcg_top
`default_nettype none
module testbench import pwmcg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic ch; logic fmt; logic [15:0] val, per, mp, hi;} pwmcg_row_t;
  localparam int TK = TB_1US_CYC;  // cycles per 1 us tick
  logic        core_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, sel = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        avs_waitrequest;
  logic [1:0]  pwm_out;
  int          mismatches = 0, check_count = 0, cyc = 0, n, hi_cyc, per_cyc;
  // ordinary cases: channel, format, value, period, minimum, expected high ticks
  pwmcg_row_t  rows [8] = '{'{0, 0, 500, 10, 2, 5}, '{1, 0, 250, 8, 0, 2}, '{0, 1, 13824, 10, 2, 5},
    '{1, 1, 6912, 12, 2, 3}, '{0, 0, 100, 10, 2, 0}, '{1, 0, 900, 10, 2, 10},
    '{0, 0, 1000, 5, 0, 5}, '{1, 0, 0, 6, 0, 0}};
  pwmcg_top pwmcg_top_inst (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pwm_out(pwm_out));
  pwmcg_actuator pwmcg_actuator_inst (.core_clk(core_clk), .line_in(pwm_out[sel]),
    .hi_cyc(hi_cyc), .per_cyc(per_cyc));
  always #25 core_clk = ~core_clk;
  // hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      final_report();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [5:0] ad(input logic ch, input logic [3:0] r);
    return {2'h0, ch, r[2:0]};
  endfunction
  function automatic logic [31:0] ctl(input logic [1:0] tb, input logic f, t, e);
    return {26'h0, tb, 1'b0, f, t, e};
  endfunction
  // one bus cycle held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // count high cycles of the selected line over a window
  task automatic count_hi(input int len);
    n = 0;
    repeat (len) begin
      @(posedge core_clk);
      if (pwm_out[sel] === 1'b1) n++;
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (rows[i]) begin
      sel = rows[i].ch;
      bus(1, ad(sel, REG_VALUE), rows[i].val);
      bus(1, ad(sel, REG_PERIOD), rows[i].per);
      bus(1, ad(sel, REG_MINPW), rows[i].mp);
      bus(1, ad(sel, REG_CTRL), ctl(2, rows[i].fmt, 0, 1));
      repeat (rows[i].per * TK * 2 + TK) @(posedge core_clk);
      count_hi(rows[i].per * TK);
      check(n, rows[i].hi * TK);
      bus(0, ad(sel, REG_STATUS), 0);
      check(rd[31:16], rows[i].hi);
      check(rd[0], 1'b1);
      if (rows[i].hi != 0 && rows[i].hi != rows[i].per) check(per_cyc, rows[i].per * TK);
      bus(1, ad(sel, REG_CTRL), 0);
    end
    // on-delay: line stays low for five ticks after enable
    sel = 0;
    bus(1, ad(0, REG_PERIOD), 10);
    bus(1, ad(0, REG_VALUE), 500);
    bus(1, ad(0, REG_ONDLY), 5);
    bus(1, ad(0, REG_CTRL), ctl(2, 0, 0, 1));
    n = 0;
    while (pwm_out[0] !== 1'b1 && n < 8 * TK) begin
      @(posedge core_clk);
      n++;
    end
    check(n >= 5 * TK - 4 && n <= 6 * TK, 1);
    // pulse train selected: pwm line silent, then back to pwm
    bus(1, ad(0, REG_CTRL), ctl(2, 0, 1, 1));
    count_hi(10 * TK);
    check(n, 0);
    bus(1, ad(0, REG_CTRL), ctl(2, 0, 0, 1));
    repeat (30 * TK) @(posedge core_clk);
    count_hi(10 * TK);
    check(n, 5 * TK);
    // limits: on-delay top, period and minimum clamped
    bus(1, ad(0, REG_ONDLY), ONDLY_MAX);
    bus(0, ad(0, REG_ONDLY), 0);
    check(rd[15:0], 16'hffff);
    bus(1, ad(0, REG_PERIOD), 100);
    bus(0, ad(0, REG_PERIOD), 0);
    check(rd[15:0], PERIOD_MAX);
    bus(1, ad(0, REG_PERIOD), 10);
    bus(1, ad(0, REG_MINPW), 9);
    bus(0, ad(0, REG_MINPW), 0);
    check(rd[15:0], 16'h0005);
    // 0.1 ms time base on channel 1
    sel = 1;
    bus(1, ad(1, REG_VALUE), 500);
    bus(1, ad(1, REG_PERIOD), 2);
    bus(1, ad(1, REG_CTRL), ctl(1, 0, 0, 1));
    repeat (6 * TB_100US_CYC) @(posedge core_clk);
    check(per_cyc, 2 * TB_100US_CYC);
    check(hi_cyc, TB_100US_CYC);
    // reset in mid-run, then defaults
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(pwm_out, 2'h0);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    bus(0, ad(0, REG_CTRL), 0);
    check(rd, 32'h10);
    bus(0, ad(1, REG_ONDLY), 0);
    check(rd, 32'h0);
    bus(0, ad(1, REG_PERIOD), 0);
    check(rd[15:0], PERIOD_RESET);
    bus(0, ad(0, REG_MINPW), 0);
    check(rd[15:0], 16'h0002);
    // no third channel behind the upper addresses
    bus(1, 6'h10, 32'h1);
    bus(0, 6'h10, 0);
    check(rd, UNMAPPED_READ);
    final_report();
  end
endmodule
`default_nettype wire
